// ---- hdl/ssr_receiver.sv ----
// Synchronous slave serial receiver with an AXI4-Lite register file.
`timescale 1ns/10ps
module ssr_receiver #(
	parameter int ADDR_W = 8
) (
	input wire logic CLK_I,
	input wire logic RSTN_I,
	input wire logic [ADDR_W-1:0] AWADDR_I,
	input wire logic AWVALID_I,
	output logic AWREADY_O,
	input wire logic [31:0] WDATA_I,
	input wire logic [3:0] WSTRB_I,
	input wire logic WVALID_I,
	output logic WREADY_O,
	output logic [1:0] BRESP_O,
	output logic BVALID_O,
	input wire logic BREADY_I,
	input wire logic [ADDR_W-1:0] ARADDR_I,
	input wire logic ARVALID_I,
	output logic ARREADY_O,
	output logic [31:0] RDATA_O,
	output logic [1:0] RRESP_O,
	output logic RVALID_O,
	input wire logic RREADY_I,
	input wire logic SHIFT_CLOCK_PIN_I,
	input wire logic SERIAL_DATA_PIN_I,
	output logic IRQ_O,
	output logic WAKE_O
);
	import ssr_pkg::*;

	typedef struct packed {
		logic ck_m;
		logic ck_s;
		logic ck_l;
		logic dt_m;
		logic dt_s;
		logic clock_source_select;
		logic sync_mode;
		logic serial_port_enable;
		logic ninth_bit_receive_enable;
		logic single_receive_enable;
		logic continuous_receive_enable;
		logic overrun_error_flag;
		logic received_ninth_bit;
		logic data_pin_polarity;
		logic clock_pin_polarity;
		logic global_interrupt_enable;
		logic peripheral_interrupt_enable;
		logic [7:0] received_word;
		logic receive_complete_flag;
		logic [8:0] receive_shift_register;
		logic [3:0] bit_cnt;
		logic [EVT_W-1:0] evt_stat;
		logic [EVT_W-1:0] evt_mask;
		logic aw_held;
		logic [ADDR_W-1:0] aw_addr;
		logic w_held;
		logic [7:0] w_data;
		logic w_lane0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
	} ssr_state_t;

	ssr_state_t q;
	ssr_state_t d;
	logic ck_now;
	logic fall_w;
	logic en_w;
	logic done_w;
	logic bit_in;
	logic [3:0] nbits;
	logic [8:0] sh_next;
	logic [EVT_W-1:0] evt_set;
	logic [EVT_W-1:0] evt_clr;
	logic [7:0] rd_val;
	logic rd_hit;
	logic wr_hit;

	// Bus handshakes come straight from the held state so that each channel is taken once.
	assign AWREADY_O = ~q.aw_held & ~q.bvalid;
	assign WREADY_O = ~q.w_held & ~q.bvalid;
	assign ARREADY_O = ~q.rvalid;
	assign BVALID_O = q.bvalid;
	assign BRESP_O = q.bresp;
	assign RVALID_O = q.rvalid;
	assign RRESP_O = q.rresp;
	assign RDATA_O = {24'h00_0000, q.rdata};

	// The wake line ignores the processor enables, the interrupt line honours them.
	assign WAKE_O = |(q.evt_stat & q.evt_mask);
	assign IRQ_O = WAKE_O & q.global_interrupt_enable
		& q.peripheral_interrupt_enable;

	// Next-state logic: synchronisers, bus slave, then the receiver so that its sets win.
	always_comb begin
		d = q;
		evt_set = '0;
		evt_clr = '0;
		rd_val = RST_REG8;
		rd_hit = 1'b1;
		wr_hit = 1'b1;
		done_w = 1'b0;
		// Two flops on each pin before anything looks at it.
		d.ck_m = SHIFT_CLOCK_PIN_I;
		d.ck_s = q.ck_m;
		d.dt_m = SERIAL_DATA_PIN_I;
		d.dt_s = q.dt_m;
		ck_now = q.ck_s ^ q.clock_pin_polarity;
		bit_in = q.dt_s ^ q.data_pin_polarity;
		d.ck_l = ck_now;
		fall_w = q.ck_l & ~ck_now;
		// The single-word enable takes no part here, so slave mode ignores it.
		en_w = q.serial_port_enable & q.sync_mode & ~q.clock_source_select
			& q.continuous_receive_enable & ~q.overrun_error_flag;
		nbits = q.ninth_bit_receive_enable ? WORD_BITS_9 : WORD_BITS_8;
		sh_next = {bit_in, q.receive_shift_register[8:1]};

		// Write address and data are caught separately, in either order.
		if (AWVALID_I && AWREADY_O) begin
			d.aw_held = 1'b1;
			d.aw_addr = AWADDR_I;
		end
		if (WVALID_I && WREADY_O) begin
			d.w_held = 1'b1;
			d.w_data = WDATA_I[7:0];
			d.w_lane0 = WSTRB_I[0];
		end
		if (q.bvalid && BREADY_I) begin
			d.bvalid = 1'b0;
		end
		// Only byte lane 0 carries register bits; other lanes are accepted and dropped.
		if (q.aw_held && q.w_held && !q.bvalid) begin
			d.aw_held = 1'b0;
			d.w_held = 1'b0;
			d.bvalid = 1'b1;
			case (8'(q.aw_addr))
				OFS_TX_STATUS_CONTROL: begin
					if (q.w_lane0) begin
						d.clock_source_select = q.w_data[BIT_CLOCK_SOURCE_SELECT];
						d.sync_mode = q.w_data[BIT_SYNC_MODE];
					end
				end
				OFS_RX_STATUS_CONTROL: begin
					if (q.w_lane0) begin
						d.serial_port_enable = q.w_data[BIT_SERIAL_PORT_ENABLE];
						d.ninth_bit_receive_enable = q.w_data[BIT_NINTH_BIT_RECEIVE_ENABLE];
						d.single_receive_enable = q.w_data[BIT_SINGLE_RECEIVE_ENABLE];
						d.continuous_receive_enable = q.w_data[BIT_CONTINUOUS_RECEIVE_ENABLE];
					end
				end
				OFS_BAUD_POLARITY: begin
					if (q.w_lane0) begin
						d.data_pin_polarity = q.w_data[BIT_DATA_PIN_POLARITY];
						d.clock_pin_polarity = q.w_data[BIT_CLOCK_PIN_POLARITY];
					end
				end
				OFS_RECEIVED_WORD: begin
					wr_hit = 1'b1;
				end
				OFS_EVENT_STATUS: begin
					if (q.w_lane0) begin
						evt_clr = q.w_data[EVT_W-1:0];
					end
				end
				OFS_EVENT_MASK: begin
					if (q.w_lane0) begin
						d.evt_mask = q.w_data[EVT_W-1:0];
					end
				end
				OFS_INTERRUPT_CONTROL: begin
					if (q.w_lane0) begin
						d.global_interrupt_enable = q.w_data[BIT_GLOBAL_INTERRUPT_ENABLE];
						d.peripheral_interrupt_enable = q.w_data[BIT_PERIPHERAL_INTERRUPT_ENABLE];
					end
				end
				default: begin
					wr_hit = 1'b0;
				end
			endcase
			d.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
		end

		// Reads answer one cycle after the address is taken.
		if (q.rvalid && RREADY_I) begin
			d.rvalid = 1'b0;
		end
		if (ARVALID_I && ARREADY_O) begin
			case (8'(ARADDR_I))
				OFS_TX_STATUS_CONTROL: begin
					rd_val[BIT_CLOCK_SOURCE_SELECT] = q.clock_source_select;
					rd_val[BIT_SYNC_MODE] = q.sync_mode;
				end
				OFS_RX_STATUS_CONTROL: begin
					rd_val[BIT_SERIAL_PORT_ENABLE] = q.serial_port_enable;
					rd_val[BIT_NINTH_BIT_RECEIVE_ENABLE] = q.ninth_bit_receive_enable;
					rd_val[BIT_SINGLE_RECEIVE_ENABLE] = q.single_receive_enable;
					rd_val[BIT_CONTINUOUS_RECEIVE_ENABLE] = q.continuous_receive_enable;
					rd_val[BIT_FRAMING_ERROR] = 1'b0;
					rd_val[BIT_OVERRUN_ERROR] = q.overrun_error_flag;
					rd_val[BIT_RECEIVED_NINTH_BIT] = q.received_ninth_bit;
				end
				OFS_BAUD_POLARITY: begin
					rd_val[BIT_RECEIVE_IDLE] = (q.bit_cnt == 4'h0);
					rd_val[BIT_DATA_PIN_POLARITY] = q.data_pin_polarity;
					rd_val[BIT_CLOCK_PIN_POLARITY] = q.clock_pin_polarity;
				end
				OFS_RECEIVED_WORD: begin
					// Reading the word frees the holding register for the next one.
					rd_val = q.received_word;
					d.receive_complete_flag = 1'b0;
				end
				OFS_EVENT_STATUS: begin
					rd_val[EVT_W-1:0] = q.evt_stat;
				end
				OFS_EVENT_MASK: begin
					rd_val[EVT_W-1:0] = q.evt_mask;
				end
				OFS_INTERRUPT_CONTROL: begin
					rd_val[BIT_GLOBAL_INTERRUPT_ENABLE] = q.global_interrupt_enable;
					rd_val[BIT_PERIPHERAL_INTERRUPT_ENABLE] = q.peripheral_interrupt_enable;
				end
				default: begin
					rd_hit = 1'b0;
				end
			endcase
			d.rvalid = 1'b1;
			d.rdata = rd_val;
			d.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end

		// Dropping continuous receive clears the overrun and abandons a partial word.
		if (!d.continuous_receive_enable) begin
			d.overrun_error_flag = 1'b0;
		end
		// Reception samples the pins through CLK_I flops, so it runs only while the system clock runs.
		if (!en_w) begin
			d.bit_cnt = 4'h0;
		end else if (fall_w) begin
			d.receive_shift_register = sh_next;
			d.bit_cnt = q.bit_cnt + 4'h1;
			if (q.bit_cnt + 4'h1 == nbits) begin
				done_w = 1'b1;
				d.bit_cnt = 4'h0;
				// A read in this same cycle frees the register, so the new word still lands.
				if (d.receive_complete_flag) begin
					// A clear of continuous receive in this very cycle also clears errors, so
					// the lost word then shows only as a sticky event.
					d.overrun_error_flag = d.continuous_receive_enable;
					evt_set[EVT_OVERRUN] = 1'b1;
				end else begin
					d.received_word = q.ninth_bit_receive_enable ? sh_next[7:0]
						: sh_next[8:1];
					d.received_ninth_bit = q.ninth_bit_receive_enable & sh_next[8];
					d.receive_complete_flag = 1'b1;
					evt_set[EVT_WORD_RECEIVED] = 1'b1;
				end
			end
		end
		// Sticky events: a set in the clearing cycle wins.
		d.evt_stat = (q.evt_stat & ~evt_clr) | evt_set;
	end

	// All state sits in one register; reset is synchronous.
	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RSTN_I);

	// A completed word always leaves its sticky event behind.
	a_word_flags: assert property ($rose(q.receive_complete_flag) |->
		q.evt_stat[EVT_WORD_RECEIVED])
		else $error("Word completion did not set the event bit.");

	// The processor line needs both enables and a pending wake cause.
	a_irq_gating: assert property (IRQ_O |->
		q.global_interrupt_enable && q.peripheral_interrupt_enable && WAKE_O)
		else $error("Interrupt raised with processor enables clear.");

	// An accepted word with its event unmasked must raise wake on the next cycle.
	a_wake_follow: assert property (done_w && !d.overrun_error_flag
		&& d.continuous_receive_enable && d.evt_mask[EVT_WORD_RECEIVED] |=> WAKE_O)
		else $error("Enabled completion did not raise wake.");

	// Once continuous receive has dropped no overrun may remain.
	a_continuous_receive_enable_clears: assert property ($fell(q.continuous_receive_enable) |->
		!q.overrun_error_flag)
		else $error("Overrun survived clearing continuous receive.");

	// With continuous receive off the bit counter rests at zero.
	a_idle_no_count: assert property (!q.continuous_receive_enable |=>
		q.bit_cnt == 4'h0)
		else $error("Bits counted while reception disabled.");

	// A standing overrun keeps the unread word untouched.
	a_overrun_holds: assert property (q.overrun_error_flag
		&& $past(q.overrun_error_flag) |-> $stable(q.received_word))
		else $error("Received word changed during overrun.");

	// A nine-bit word keeps counting past the eighth bit.
	a_nine_bits: assert property (en_w && fall_w && q.ninth_bit_receive_enable
		&& q.bit_cnt == 4'h7 |=> q.bit_cnt == 4'h8)
		else $error("Nine-bit word ended early.");

	// The ninth bit follows the last shifted bit, or reads zero for eight-bit words.
	a_ninth_capture: assert property ($rose(q.receive_complete_flag) |->
		q.received_ninth_bit == ($past(q.ninth_bit_receive_enable)
		&& q.receive_shift_register[8]))
		else $error("Ninth bit not captured from the shift register.");

	// An eight-bit word lands from the upper eight shift register bits.
	a_word_load: assert property ($rose(q.receive_complete_flag)
		&& !$past(q.ninth_bit_receive_enable) |->
		q.received_word == q.receive_shift_register[8:1])
		else $error("Received word does not match shifted bits.");

	// A read of the word register returns the word held when the address was taken.
	a_read_low: assert property (ARVALID_I && ARREADY_O
		&& 8'(ARADDR_I) == OFS_RECEIVED_WORD |=>
		RDATA_O == {24'h00_0000, $past(q.received_word)})
		else $error("Word read returned wrong data.");

	// Without slave mode selected the shift register never moves.
	a_gate_mode: assert property (!q.serial_port_enable || !q.sync_mode
		|| q.clock_source_select |=> $stable(q.receive_shift_register))
		else $error("Shift register moved outside slave mode.");

	// Without continuous receive the shift register never moves.
	a_continuous_receive_enable_shift: assert property (!q.continuous_receive_enable |=>
		$stable(q.receive_shift_register))
		else $error("Shift register moved with reception disabled.");

	// An eight-bit word wraps the counter on its eighth bit.
	a_eight_bits: assert property (en_w && fall_w && !q.ninth_bit_receive_enable
		&& q.bit_cnt == 4'h7 |=> q.bit_cnt == 4'h0)
		else $error("Eight-bit word did not end on its eighth bit.");

	// An overrun freezes reception until continuous receive is cleared.
	a_overrun_stop: assert property (q.overrun_error_flag |=>
		$stable(q.receive_shift_register))
		else $error("Shift register moved during overrun.");

	// Each shifted bit is the data line corrected by its polarity bit.
	a_data_pol: assert property (en_w && fall_w |=>
		q.receive_shift_register[8] == ($past(q.dt_s) ^ $past(q.data_pin_polarity)))
		else $error("Shifted bit does not follow the data polarity.");

	// Read data stand unchanged until the read response is taken.
	a_rdata_hold: assert property (RVALID_O && !RREADY_I |=>
		RVALID_O && $stable(RDATA_O) && $stable(RRESP_O))
		else $error("Read response changed before it was taken.");

	// A write response stands unchanged until it is taken.
	a_bresp_hold: assert property (BVALID_O && !BREADY_I |=>
		BVALID_O && $stable(BRESP_O))
		else $error("Write response changed before it was taken.");
endmodule

// ---- common/ssr_pkg.sv ----
// Constants shared by the synchronous slave serial receiver.
package ssr_pkg;
	// Register byte offsets on the AXI4-Lite bus.
	localparam logic [7:0] OFS_TX_STATUS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_RX_STATUS_CONTROL = 8'h04;
	localparam logic [7:0] OFS_BAUD_POLARITY = 8'h08;
	localparam logic [7:0] OFS_RECEIVED_WORD = 8'h0C;
	localparam logic [7:0] OFS_EVENT_STATUS = 8'h10;
	localparam logic [7:0] OFS_EVENT_MASK = 8'h14;
	localparam logic [7:0] OFS_INTERRUPT_CONTROL = 8'h18;
	// Transmit status and control fields.
	localparam int BIT_CLOCK_SOURCE_SELECT = 7;
	localparam int BIT_SYNC_MODE = 4;
	// Receive status and control fields.
	localparam int BIT_SERIAL_PORT_ENABLE = 7;
	localparam int BIT_NINTH_BIT_RECEIVE_ENABLE = 6;
	localparam int BIT_SINGLE_RECEIVE_ENABLE = 5;
	localparam int BIT_CONTINUOUS_RECEIVE_ENABLE = 4;
	localparam int BIT_FRAMING_ERROR = 2;
	localparam int BIT_OVERRUN_ERROR = 1;
	localparam int BIT_RECEIVED_NINTH_BIT = 0;
	// Baud and polarity control fields.
	localparam int BIT_RECEIVE_IDLE = 6;
	localparam int BIT_DATA_PIN_POLARITY = 5;
	localparam int BIT_CLOCK_PIN_POLARITY = 4;
	// Interrupt control fields.
	localparam int BIT_GLOBAL_INTERRUPT_ENABLE = 7;
	localparam int BIT_PERIPHERAL_INTERRUPT_ENABLE = 6;
	// Event status and mask fields.
	localparam int EVT_WORD_RECEIVED = 0;
	localparam int EVT_OVERRUN = 1;
	localparam int EVT_W = 2;
	// Word lengths in bits.
	localparam logic [3:0] WORD_BITS_8 = 4'h8;
	localparam logic [3:0] WORD_BITS_9 = 4'h9;
	// Reset values.
	localparam logic [7:0] RST_REG8 = 8'h00;
	// AXI response codes.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- tb/ssr_master_model.sv ----
// Behavioural synchronous master that clocks words into the receiver.
`timescale 1ns/10ps
module ssr_master_model (
	input wire logic start_i,
	input wire logic [8:0] word_i,
	input wire logic nine_i,
	input wire logic ck_inv_i,
	input wire logic dt_inv_i,
	output logic ck_o,
	output logic dt_o,
	output logic busy_o
);
	int i;
	// The clock rests at its idle level between frames, and the data line flips after a frame
	// so that a stale bit can never pass for a good one.
	initial begin
		busy_o = 1'b0;
		dt_o = 1'b0;
		ck_o = 1'b1;
		forever begin
			@(posedge start_i or ck_inv_i);
			ck_o = !ck_inv_i;
			if (start_i) begin
				busy_o = 1'b1;
				#37;
				for (i = 0; i < (nine_i ? 9 : 8); i++) begin
					dt_o = word_i[i] ^ dt_inv_i;
					#400 ck_o = ck_inv_i;
					#400 ck_o = !ck_inv_i;
				end
				dt_o = !dt_o;
				busy_o = 1'b0;
			end
		end
	end
endmodule

// ---- tb/ssr_receiver_tb_top.sv ----
// Self-checking bench for the synchronous slave serial receiver.
`timescale 1ns/10ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin failures++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module ssr_receiver_tb_top;
	import ssr_pkg::*;
	logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, m_start, m_nine, m_ck, m_dt, nn;
	logic awready, wready, bvalid, arready, rvalid, irq, wake, ck_pin, dt_pin, m_busy;
	logic [7:0] awaddr, araddr, rxc;
	logic [31:0] wdata, rdata, seed;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, eb;
	logic [8:0] m_word, w;
	logic [33:0] exp_r[$];
	logic [1:0] exp_b[$];
	logic [33:0] e;
	int failures, total_checks, i;
	// Free-running system clock.
	always #50 clk = !clk;
	ssr_receiver i_dut (.CLK_I(clk), .RSTN_I(rst_n), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
		.AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid),
		.WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
		.ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
		.RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready), .SHIFT_CLOCK_PIN_I(ck_pin),
		.SERIAL_DATA_PIN_I(dt_pin), .IRQ_O(irq), .WAKE_O(wake));
	ssr_master_model i_master (.start_i(m_start), .word_i(m_word), .nine_i(m_nine),
		.ck_inv_i(m_ck), .dt_inv_i(m_dt), .ck_o(ck_pin), .dt_o(dt_pin), .busy_o(m_busy));
	// Responses are matched in order against the notes left by the bus tasks.
	always @(posedge clk) begin
		if (rvalid && rready) begin
			e = exp_r.pop_front();
			`CHK({rresp, rdata}, e)
		end
		if (bvalid && bready) begin
			eb = exp_b.pop_front();
			`CHK(bresp, eb)
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic final_report();
		if (failures == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic tmo();
		failures++;
		final_report();
	endtask
	// Address and data are offered together and each is dropped once taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		exp_b.push_back(er);
		do begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (++n > 50) tmo();
		end while (!(bvalid && bready));
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [33:0] ex);
		int n;
		n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		exp_r.push_back(ex);
		do begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (++n > 50) tmo();
		end while (!(rvalid && rready));
		rready <= 1'b0;
	endtask
	// One frame from the master; the tail allows for the pin synchronisers.
	task automatic send(input logic [8:0] wd, input logic nine);
		int n;
		n = 0;
		@(posedge clk);
		m_word <= wd;
		m_nine <= nine;
		m_start <= 1'b1;
		@(posedge clk);
		m_start <= 1'b0;
		do begin
			@(posedge clk);
			if (++n > 300) tmo();
		end while (m_busy || n < 3);
		repeat (6) @(posedge clk);
	endtask
	// Main sequence.
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, m_start, m_nine, m_ck, m_dt} = 9'h000;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0000_0000;
		wstrb = 4'h1;
		m_word = 9'h000;
		seed = 32'h0000_7e71;
		failures = 0;
		total_checks = 0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		for (i = 0; i < 7; i++) begin
			rd(8'(4 * i), {RESP_OKAY, (i == 2) ? 32'h0000_0040 : 32'h0000_0000});
		end
		rd(8'h1C, {RESP_SLVERR, 32'h0000_0000});
		wr(8'h1C, 32'h0000_00FF, RESP_SLVERR);
		wr(OFS_TX_STATUS_CONTROL, 32'h0000_0010, RESP_OKAY);
		wr(OFS_EVENT_MASK, 32'h0000_0003, RESP_OKAY);
		// Every polarity pair, both word lengths, and the single enable set once.
		for (i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			w = seed[8:0];
			nn = i[0] ^ i[1];
			rxc = {1'b1, nn, i == 3, 5'h00};
			m_ck <= i[0];
			m_dt <= i[1];
			wr(OFS_BAUD_POLARITY, {26'h0, i[1], i[0], 4'h0}, RESP_OKAY);
			wr(OFS_INTERRUPT_CONTROL, i[0] ? 32'h0000_0080 : 32'h0000_00C0, RESP_OKAY);
			wr(OFS_RX_STATUS_CONTROL, {24'h0, rxc | 8'h10}, RESP_OKAY);
			send(w, nn);
			`CHK(wake, 1'b1)
			`CHK(irq, !i[0])
			rd(OFS_RX_STATUS_CONTROL, {RESP_OKAY, 24'h0, rxc | 8'h10 | (nn & w[8])});
			rd(OFS_EVENT_STATUS, {RESP_OKAY, 32'h0000_0001});
			rd(OFS_RECEIVED_WORD, {RESP_OKAY, 24'h0, w[7:0]});
			wr(OFS_EVENT_STATUS, 32'h0000_0001, RESP_OKAY);
			`CHK(wake, 1'b0)
			wr(OFS_RX_STATUS_CONTROL, {24'h0, rxc}, RESP_OKAY);
		end
		// A second unread word overruns and reception stays stopped even after a read.
		wr(OFS_RX_STATUS_CONTROL, 32'h0000_0090, RESP_OKAY);
		send(9'h0A5, 1'b0);
		send(9'h05A, 1'b0);
		rd(OFS_RX_STATUS_CONTROL, {RESP_OKAY, 32'h0000_0092});
		rd(OFS_EVENT_STATUS, {RESP_OKAY, 32'h0000_0003});
		rd(OFS_RECEIVED_WORD, {RESP_OKAY, 32'h0000_00A5});
		send(9'h03C, 1'b0);
		rd(OFS_RECEIVED_WORD, {RESP_OKAY, 32'h0000_00A5});
		wr(OFS_RX_STATUS_CONTROL, 32'h0000_0080, RESP_OKAY);
		rd(OFS_RX_STATUS_CONTROL, {RESP_OKAY, 32'h0000_0080});
		wr(OFS_EVENT_STATUS, 32'h0000_0003, RESP_OKAY);
		// A write with byte lane 0 off is answered but leaves the register alone.
		wstrb <= 4'hE;
		wr(OFS_EVENT_MASK, 32'h0000_0000, RESP_OKAY);
		wstrb <= 4'h1;
		rd(OFS_EVENT_MASK, {RESP_OKAY, 32'h0000_0003});
		// Continuous enable off, then the internal clock source: neither may receive.
		for (i = 0; i < 2; i++) begin
			wr(OFS_TX_STATUS_CONTROL, i ? 32'h0000_0090 : 32'h0000_0010, RESP_OKAY);
			wr(OFS_RX_STATUS_CONTROL, i ? 32'h0000_0090 : 32'h0000_0080, RESP_OKAY);
			send(9'h0FF, 1'b0);
			rd(OFS_EVENT_STATUS, {RESP_OKAY, 32'h0000_0000});
			`CHK(wake, 1'b0)
		end
		final_report();
	end
endmodule
